// ==== hw/lor_pkg.sv ====
package lor_pkg;

	// Register indices; byte address is four times the index
	localparam logic [3:0]  IDX_FRAME_VCM   = 4'h6;
	localparam logic [3:0]  IDX_LEVEL_CTRL  = 4'h7;
	localparam logic [3:0]  IDX_FORMAT_PRE  = 4'h8;

	localparam logic [15:0] RST_FRAME_VCM   = 16'h36d6;
	localparam logic [15:0] RST_LEVEL_CTRL  = 16'h0000;
	localparam logic [15:0] RST_FORMAT_PRE  = 16'h0120;

	// Writable bit masks; zero bits are read-only reserved
	localparam logic [15:0] WMASK_FRAME_VCM  = 16'hffff;
	localparam logic [15:0] WMASK_LEVEL_CTRL = 16'h7fff;
	localparam logic [15:0] WMASK_FORMAT_PRE = 16'h01ff;

	// Field positions
	localparam int POS_LCLK_ON      = 15;
	localparam int POS_FR3_VCM      = 12;
	localparam int POS_FR2_VCM      = 9;
	localparam int POS_FR1_VCM      = 6;
	localparam int POS_FR0_VCM      = 3;
	localparam int POS_FR3_PWR      = 0;
	localparam int POS_LFR_VCM      = 13;
	localparam int POS_LCLK_VCM     = 11;
	localparam int POS_LFR_PREDRV   = 9;
	localparam int POS_LCLK_PREDRV  = 7;
	localparam int POS_LFR_CML      = 4;
	localparam int POS_LCLK_CML     = 1;
	localparam int POS_LFR_ON       = 0;
	localparam int POS_PREDIV       = 6;
	localparam int POS_RSVD_ONE     = 5;
	localparam int POS_LOGIC_EN     = 4;
	localparam int POS_LFR_FMT      = 2;
	localparam int POS_LCLK_FMT     = 0;

	typedef enum logic [1:0] {
		LOR_FMT_LVDS   = 2'h0,
		LOR_FMT_LVPECL = 2'h1,
		LOR_FMT_CML    = 2'h2,
		LOR_FMT_RSVD   = 2'h3
	} lor_fmt_e;

	localparam logic [2:0] PREDIV_1 = 3'h1;
	localparam logic [2:0] PREDIV_2 = 3'h2;
	localparam logic [2:0] PREDIV_4 = 3'h4;

	// Settings of one logic output as applied to the analog driver
	typedef struct packed {
		logic       bufferOn;
		lor_fmt_e   format;
		logic [1:0] commonMode;
		logic [1:0] predriverPower;
		logic [2:0] cmlPower;
		logic       lvdsActive;
		logic       cmlActive;
	} lor_drv_s;

	// Settings of the frame-reference outputs: common modes of all four, power of the fourth
	typedef struct packed {
		logic [2:0] commonMode3;
		logic [2:0] commonMode2;
		logic [2:0] commonMode1;
		logic [2:0] commonMode0;
		logic [2:0] power3;
	} lor_frame_s;

endpackage : lor_pkg

// ==== hw/lor_logic_output_regs.sv ====
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps

module lor_logic_output_regs #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     hsel,
	input  wire logic [ADDR_WIDTH-1:0]    haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	output lor_pkg::lor_drv_s             logicClockOutput,
	output lor_pkg::lor_drv_s             logicFrameRefOutput,
	output lor_pkg::lor_frame_s           frameRefSettings,
	output logic [2:0]                    logicClockPredivider,
	output logic                          logicSubsystemOn
);
	import lor_pkg::*;

	// Elaboration checks; a bad setting stops the build instead of aliasing registers
	if (ADDR_WIDTH < 6) begin : gAddrTooNarrow
		$error("ADDR_WIDTH must reach byte address 0x20");
	end

	if (ADDR_WIDTH > 32) begin : gAddrTooWide
		$error("ADDR_WIDTH must not exceed the bus address width");
	end

	if (int'(IDX_FORMAT_PRE) >= (1 << (ADDR_WIDTH - 2))) begin : gIdxRange
		$error("Register index beyond the decoded address range");
	end

	if (IDX_FRAME_VCM == IDX_LEVEL_CTRL || IDX_LEVEL_CTRL == IDX_FORMAT_PRE) begin : gIdxClash
		$error("Two registers share one index");
	end

	if ((RST_FRAME_VCM & ~WMASK_FRAME_VCM) != 16'h0000) begin : gFrameRsvd
		$error("Read-only bits of the frame register must reset to zero");
	end

	if ((RST_LEVEL_CTRL & ~WMASK_LEVEL_CTRL) != 16'h0000) begin : gLevelRsvd
		$error("Read-only bits of the level register must reset to zero");
	end

	if ((RST_FORMAT_PRE & ~WMASK_FORMAT_PRE) != 16'h0000) begin : gFormatRsvd
		$error("Read-only bits of the format register must reset to zero");
	end

	if (RST_FORMAT_PRE[POS_PREDIV +: 3] != PREDIV_4) begin : gPredivRst
		$error("Predivider reset code must match the output reset value");
	end

	if (RST_FORMAT_PRE[POS_RSVD_ONE] != 1'b1) begin : gRsvdOneRst
		$error("Reserved format bit must reset to one");
	end

	if (RST_FORMAT_PRE[POS_LOGIC_EN] != 1'b0) begin : gMasterRst
		$error("Subsystem enable must reset to off");
	end

	if (RST_FRAME_VCM[POS_LCLK_ON] != 1'b0) begin : gClkOnRst
		$error("Logic clock buffer must reset to off");
	end

	if (RST_LEVEL_CTRL[POS_LFR_ON] != 1'b0) begin : gFrameOnRst
		$error("Logic frame buffer must reset to off");
	end

	// The common-mode loop below assumes four evenly spaced 3-bit fields
	if (POS_FR0_VCM + 9 != POS_FR3_VCM || POS_FR3_VCM + 3 > 16) begin : gFramePos
		$error("Frame common-mode fields must be evenly spaced");
	end

	if (POS_LCLK_ON > 15 || POS_LFR_VCM + 2 > 16) begin : gLevelPos
		$error("Field positions must lie inside a 16-bit register");
	end

	if (POS_PREDIV + 3 > 16 || POS_LFR_CML + 3 > 16) begin : gFormatPos
		$error("Field positions must lie inside a 16-bit register");
	end

	logic [15:0]           frameVcm;
	logic [15:0]           levelCtrl;
	logic [15:0]           formatPre;
	logic                  wrPending;
	logic [ADDR_WIDTH-1:0] wrAddr;

	// Address phase decode
	wire                  addrPhase = hsel && htrans[1] && hready;
	wire                  rdStrobe  = addrPhase && !hwrite;
	wire                  wordAligned = (haddr[1:0] == 2'h0);
	wire [ADDR_WIDTH-3:0] rdIndex = haddr[ADDR_WIDTH-1:2];
	wire [ADDR_WIDTH-3:0] wrIndex = wrAddr[ADDR_WIDTH-1:2];
	wire                  wrAligned = (wrAddr[1:0] == 2'h0);

	wire hitWrFrame  = wrPending && wrAligned && (wrIndex == (ADDR_WIDTH-2)'(IDX_FRAME_VCM));
	wire hitWrLevel  = wrPending && wrAligned && (wrIndex == (ADDR_WIDTH-2)'(IDX_LEVEL_CTRL));
	wire hitWrFormat = wrPending && wrAligned && (wrIndex == (ADDR_WIDTH-2)'(IDX_FORMAT_PRE));

	wire hitRdFrame  = wordAligned && (rdIndex == (ADDR_WIDTH-2)'(IDX_FRAME_VCM));
	wire hitRdLevel  = wordAligned && (rdIndex == (ADDR_WIDTH-2)'(IDX_LEVEL_CTRL));
	wire hitRdFormat = wordAligned && (rdIndex == (ADDR_WIDTH-2)'(IDX_FORMAT_PRE));

	// reserved bits read zero even if a stored bit were ever set
	wire [15:0] rdFrame  = frameVcm  & WMASK_FRAME_VCM;
	wire [15:0] rdLevel  = levelCtrl & WMASK_LEVEL_CTRL;
	wire [15:0] rdFormat = formatPre & WMASK_FORMAT_PRE;

	// Unmapped addresses read zero and swallow writes
	wire [15:0] rdSelect = hitRdFrame  ? rdFrame  :
	                       hitRdLevel  ? rdLevel  :
	                       hitRdFormat ? rdFormat : 16'h0000;

	wire [15:0] wrData = hwdata[15:0];
	wire [15:0] next_frameVcm  = (wrData & WMASK_FRAME_VCM)  | (frameVcm  & ~WMASK_FRAME_VCM);
	wire [15:0] next_levelCtrl = (wrData & WMASK_LEVEL_CTRL) | (levelCtrl & ~WMASK_LEVEL_CTRL);
	wire [15:0] next_formatPre = (wrData & WMASK_FORMAT_PRE) | (formatPre & ~WMASK_FORMAT_PRE);

	// Bus side: zero wait states, so a write lands at the end of its data phase
	always_ff @(posedge clock) begin
		if (rst) begin
			wrPending <= 1'b0;
		end else begin
			wrPending <= addrPhase && hwrite;
		end
	end

	// Address kept for the data phase; only meaningful while wrPending is high
	always_ff @(posedge clock) begin
		if (rst) begin
			wrAddr <= '0;
		end else begin
			wrAddr <= haddr;
		end
	end

	// Read data taken in the address phase, standing until the next read
	always_ff @(posedge clock) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (rdStrobe) begin
			hrdata <= {16'h0000, rdSelect};
		end
	end

	// Never busy, and unmapped addresses are answered OKAY as well
	always_ff @(posedge clock) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			frameVcm <= RST_FRAME_VCM;
		end else if (hitWrFrame) begin
			frameVcm <= next_frameVcm;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			levelCtrl <= RST_LEVEL_CTRL;
		end else if (hitWrLevel) begin
			levelCtrl <= next_levelCtrl;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			formatPre <= RST_FORMAT_PRE;
		end else if (hitWrFormat) begin
			formatPre <= next_formatPre;
		end
	end

	// Field extraction
	wire       masterOn    = formatPre[POS_LOGIC_EN];
	wire [2:0] predivCode  = formatPre[POS_PREDIV +: 3];
	wire [1:0] lfrFmtCode  = formatPre[POS_LFR_FMT +: 2];
	wire [1:0] lclkFmtCode = formatPre[POS_LCLK_FMT +: 2];
	wire       lclkOnReq   = frameVcm[POS_LCLK_ON];
	wire       lfrOnReq    = levelCtrl[POS_LFR_ON];
	wire [1:0] lclkVcm     = levelCtrl[POS_LCLK_VCM +: 2];
	wire [1:0] lfrVcm      = levelCtrl[POS_LFR_VCM +: 2];
	wire [1:0] lclkPredrv  = levelCtrl[POS_LCLK_PREDRV +: 2];
	wire [1:0] lfrPredrv   = levelCtrl[POS_LFR_PREDRV +: 2];
	wire [2:0] frame3Power = frameVcm[POS_FR3_PWR +: 3];

	wire predivLegal = (predivCode == PREDIV_1) || (predivCode == PREDIV_2) ||
	                   (predivCode == PREDIV_4);

	// Illegal codes keep the last good setting; reset matches divide by four
	wire [2:0] next_predivider = predivLegal ? predivCode : logicClockPredivider;

	// reserved format falls back to LVDS
	wire [1:0] lfrFmt  = (lfrFmtCode == LOR_FMT_RSVD) ? LOR_FMT_LVDS : lfrFmtCode;
	wire [1:0] lclkFmt = (lclkFmtCode == LOR_FMT_RSVD) ? LOR_FMT_LVDS : lclkFmtCode;

	wire [2:0] lfrCmlRaw  = levelCtrl[POS_LFR_CML +: 3];
	wire [2:0] lfrCml     = lfrCmlRaw[2] ? 3'h3 : lfrCmlRaw;
	wire [2:0] lclkCmlRaw = levelCtrl[POS_LCLK_CML +: 3];
	wire [2:0] lclkCml    = lclkCmlRaw[2] ? 3'h3 : lclkCmlRaw;

	wire lclkOn = masterOn && lclkOnReq;
	wire lfrOn  = masterOn && lfrOnReq;

	// format decides which level field takes effect
	wire lclkLvdsOn = lclkOn && (lclkFmt == LOR_FMT_LVDS);
	wire lclkCmlOn  = lclkOn && (lclkFmt == LOR_FMT_CML);
	wire lfrLvdsOn  = lfrOn && (lfrFmt == LOR_FMT_LVDS);
	wire lfrCmlOn   = lfrOn && (lfrFmt == LOR_FMT_CML);

	// frame common modes, one field per output
	wire [2:0] frameCm [4];
	for (genvar g = 0; g < 4; g++) begin : gFrameCm
		assign frameCm[g] = frameVcm[POS_FR0_VCM + 3 * g +: 3];
	end

	lor_drv_s   next_lclk;
	lor_drv_s   next_lfr;
	lor_frame_s next_frame;

	always_comb begin
		next_lclk                = '0;
		next_lclk.bufferOn       = lclkOn;
		next_lclk.format         = lor_fmt_e'(lclkFmt);
		next_lclk.commonMode     = lclkVcm;
		next_lclk.predriverPower = lclkPredrv;
		next_lclk.cmlPower       = lclkCml;
		next_lclk.lvdsActive     = lclkLvdsOn;
		next_lclk.cmlActive      = lclkCmlOn;
	end

	always_comb begin
		next_lfr                = '0;
		next_lfr.bufferOn       = lfrOn;
		next_lfr.format         = lor_fmt_e'(lfrFmt);
		next_lfr.commonMode     = lfrVcm;
		next_lfr.predriverPower = lfrPredrv;
		next_lfr.cmlPower       = lfrCml;
		next_lfr.lvdsActive     = lfrLvdsOn;
		next_lfr.cmlActive      = lfrCmlOn;
	end

	always_comb begin
		next_frame             = '0;
		next_frame.commonMode3 = frameCm[3];
		next_frame.commonMode2 = frameCm[2];
		next_frame.commonMode1 = frameCm[1];
		next_frame.commonMode0 = frameCm[0];
		next_frame.power3      = frame3Power;
	end

	// Outputs registered one cycle behind the bank, so drivers never see decode glitches
	always_ff @(posedge clock) begin
		if (rst) begin
			logicClockOutput <= '0;
		end else begin
			logicClockOutput <= next_lclk;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			logicFrameRefOutput <= '0;
		end else begin
			logicFrameRefOutput <= next_lfr;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			frameRefSettings <= '0;
		end else begin
			frameRefSettings <= next_frame;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			logicClockPredivider <= PREDIV_4;
		end else begin
			logicClockPredivider <= next_predivider;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			logicSubsystemOn <= 1'b0;
		end else begin
			logicSubsystemOn <= masterOn;
		end
	end

endmodule : lor_logic_output_regs

// ==== dv/lor_regs_asserts.sv ====
`timescale 1ns/10ps
module lor_regs_asserts import lor_pkg::*; #(parameter int ADDR_WIDTH = 8) (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [ADDR_WIDTH-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire lor_drv_s logicClockOutput,
	input wire lor_drv_s logicFrameRefOutput,
	input wire logic [2:0] logicClockPredivider,
	input wire logic logicSubsystemOn
);
	logic hit;
	// Write to the format register taken this edge
	always_ff @(posedge clock) hit <= !rst && hsel && htrans[1] && hready && hwrite
		&& haddr == ADDR_WIDTH'({IDX_FORMAT_PRE, 2'h0});
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_master_gate: assert property (!logicSubsystemOn |->
		!logicClockOutput.bufferOn && !logicFrameRefOutput.bufferOn) else $error("buffer on");
	a_enable_follows: assert property (hit |-> ##2
		logicSubsystemOn == $past(hwdata[4], 2)) else $error("enable did not follow");
	a_reset_vals: assert property ($past(rst) |->
		logicClockPredivider == 3'h4 && !logicSubsystemOn) else $error("bad reset outputs");
	a_prediv_legal: assert property (logicClockPredivider inside {3'h1, 3'h2, 3'h4})
		else $error("illegal predivider");
	a_upper_zero: assert property (hrdata[31:16] == 16'h0) else $error("upper read bits");
	a_clk_cml: assert property (logicClockOutput.bufferOn &&
		logicClockOutput.format == LOR_FMT_CML |->
		logicClockOutput.cmlActive && !logicClockOutput.lvdsActive) else $error("clock cml");
	a_frame_cml: assert property (logicFrameRefOutput.bufferOn &&
		logicFrameRefOutput.format == LOR_FMT_CML |->
		logicFrameRefOutput.cmlActive && !logicFrameRefOutput.lvdsActive) else $error("frame cml");
	a_clk_active_on: assert property (logicClockOutput.cmlActive ||
		logicClockOutput.lvdsActive |-> logicClockOutput.bufferOn) else $error("clock off active");
	a_always_ready: assert property (hreadyout) else $error("wait state seen");
	a_okay_resp: assert property (!hresp) else $error("error response");
	a_clk_power: assert property (logicClockOutput.cmlPower <= 3'h3) else $error("clock power");
	a_frame_power: assert property (logicFrameRefOutput.cmlPower <= 3'h3) else $error("frame pwr");
endmodule : lor_regs_asserts
bind lor_logic_output_regs lor_regs_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) uChk (.clock(clock),
	.rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.logicClockOutput(logicClockOutput),
	.logicFrameRefOutput(logicFrameRefOutput), .logicClockPredivider(logicClockPredivider),
	.logicSubsystemOn(logicSubsystemOn));

// ==== dv/lor_logic_output_regs_tb.sv ====
`timescale 1ns/10ps
module lor_logic_output_regs_tb;
	import lor_pkg::*;
	logic clock = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, on;
	logic [7:0] haddr = 8'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, rd, r;
	lor_drv_s lclk, lfr;
	lor_frame_s frs;
	logic [2:0] pdiv;
	logic [15:0] m [6:8];
	logic [15:0] d;
	logic [3:0] i;
	int n_errors = 0, cmp_count = 0;
	always #2 clock = ~clock;
	lor_logic_output_regs dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .logicClockOutput(lclk),
		.logicFrameRefOutput(lfr), .frameRefSettings(frs), .logicClockPredivider(pdiv),
		.logicSubsystemOn(on));
	task automatic close_out();
		if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Hangs on a stuck hreadyout are cut by the watchdog
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] dt);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= dt;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rd = hrdata;
		chk(hresp, 0);
	endtask : xfer
	// Software side keeps reserved codes out
	function automatic logic [15:0] legal(input logic [3:0] k, input logic [15:0] v);
		if (k == 4'h7) v = v & 16'hffb7;
		if (k == 4'h8) begin
			v[8:6] = 3'h1 << (v[7:6] % 3);
			v[5] = 1'b1;
			v[2] = v[2] & ~v[3];
			v[0] = v[0] & ~v[1];
		end
		return v;
	endfunction : legal
	task automatic chk_all();
		for (int k = 6; k <= 8; k++) begin
			xfer(0, 8'(k * 4), 32'h0);
			chk(rd, {16'h0, m[k]});
		end
		chk(on, m[8][4]);
		chk(pdiv, m[8][8:6]);
		chk(frs, m[6][14:0]);
		chk(lclk.bufferOn, m[6][15] & m[8][4]);
		chk(lfr.bufferOn, m[7][0] & m[8][4]);
		chk({lclk.format, lclk.commonMode, lclk.predriverPower, lclk.cmlPower},
			{m[8][1:0], m[7][12:11], m[7][8:7], m[7][3:1]});
		chk({lfr.format, lfr.commonMode, lfr.predriverPower, lfr.cmlPower},
			{m[8][3:2], m[7][14:13], m[7][10:9], m[7][6:4]});
	endtask : chk_all
	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		m[6] = 16'h36d6;
		m[7] = 16'h0000;
		m[8] = 16'h0120;
		chk_all();
	endtask : do_reset
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
	initial begin
		void'($urandom(94));
		do_reset();
		for (int n = 0; n < 40; n++) begin
			i = 4'(6 + $urandom % 3);
			r = $urandom;
			d = legal(i, r[15:0]);
			// Corner: both buffers requested while the subsystem is still off
			if (n == 0) begin
				i = 4'h6;
				d = 16'hb6d6;
			end
			if (n == 1) begin
				i = 4'h7;
				d = 16'h0001;
			end
			xfer(1, {2'h0, i, 2'h0}, {r[31:16], d});
			m[i] = d & (i == 4'h6 ? WMASK_FRAME_VCM : i == 4'h7 ? WMASK_LEVEL_CTRL : WMASK_FORMAT_PRE);
			chk_all();
		end
		xfer(1, 8'h24, 32'hffffffff);
		xfer(0, 8'h24, 32'h0);
		chk(rd, 0);
		do_reset();
		close_out();
	end
endmodule : lor_logic_output_regs_tb
